// ==== pbc_config_space.sv ====
// Bridge configuration space with secondary interrupt steering
`default_nettype none
module pbc_config_space #(
    parameter logic [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h5678, // Arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h01, // Arbitrary value
    parameter logic [15:0] PM_CAPS = 16'h0002,
    parameter int UP_EV_W = 6,
    parameter int DN_EV_W = 7
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic cfg_req_in,
    input wire logic cfg_write_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [3:0] cfg_byte_en_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic [31:0] cfg_rdata_out,
    output logic cfg_ack_out,
    input wire logic [UP_EV_W-1:0] upstream_event_in,
    input wire logic [DN_EV_W-1:0] downstream_event_in,
    input wire logic downstream_irq_a_b_in,
    input wire logic downstream_irq_b_b_in,
    input wire logic downstream_irq_c_b_in,
    input wire logic downstream_irq_d_b_in,
    output logic core_irq_in_0_b_out,
    output logic core_irq_in_1_b_out,
    output logic core_irq_in_2_b_out,
    output logic core_irq_in_3_b_out,
    input wire logic upstream_irq_pin_a_b_in,
    input wire logic upstream_irq_pin_b_b_in,
    input wire logic upstream_irq_pin_c_b_in,
    input wire logic upstream_irq_pin_d_b_in,
    output logic upstream_irq_pin_a_b_out,
    output logic upstream_irq_pin_b_b_out,
    output logic upstream_irq_pin_c_b_out,
    output logic upstream_irq_pin_d_b_out,
    output logic upstream_irq_pin_a_oe_out,
    output logic upstream_irq_pin_b_oe_out,
    output logic upstream_irq_pin_c_oe_out,
    output logic upstream_irq_pin_d_oe_out
);
    localparam int SB = pbc_pkg::STEER_BITS;

    typedef struct packed {
        logic pend;
        logic ack;
        logic write;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic cap_flag;
        logic [SB-1:0] steer;
        logic [UP_EV_W:0] up_stat;
        logic [DN_EV_W-1:0] dn_stat;
        logic [1:0] pm_state;
        logic [SB-1:0] irq_meta;
        logic [SB-1:0] irq_sync;
        logic [SB-1:0] core_b;
        logic [SB-1:0] pin_oe;
    } pbc_state_s;

    pbc_state_s s_reg;
    pbc_state_s s_next;
    logic [1:0] rst_pipe_reg;
    logic rst_b;
    logic [31:0] mem_rdata;
    logic [31:0] be_mask;
    logic take;
    logic wr_take;
    logic [SB-1:0] irq_raw_b;

    if (UP_EV_W != 6) begin : g_up_width_check
        $error("pbc_config_space: UP_EV_W must be 6");
    end
    if (DN_EV_W < 1 || DN_EV_W > 32) begin : g_dn_width_check
        $error("pbc_config_space: DN_EV_W out of range");
    end

    // Reset is released synchronously so all state leaves reset on one edge
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_b = rst_pipe_reg[1];

    function automatic logic [31:0] wmask(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'h0};
        if (w == pbc_pkg::OFF_CMD_STAT) wmask = pbc_pkg::MASK_CMD;
        else if (w == pbc_pkg::OFF_HDR_MISC) wmask = pbc_pkg::MASK_LOW16;
        else if (w == pbc_pkg::OFF_BUS_NUM) wmask = pbc_pkg::MASK_ALL;
        else if (w == pbc_pkg::OFF_IO_WIN) wmask = pbc_pkg::MASK_LOW16;
        else if (w == pbc_pkg::OFF_MEM_WIN) wmask = pbc_pkg::MASK_ALL;
        else if (w == pbc_pkg::OFF_PF_WIN) wmask = pbc_pkg::MASK_ALL;
        else if (w == pbc_pkg::OFF_BRIDGE_CTL) wmask = pbc_pkg::MASK_HIGH16;
        else if (w == pbc_pkg::OFF_EXT_CTL) wmask = pbc_pkg::MASK_ALL;
        else if (w == pbc_pkg::OFF_ARB_CTL) wmask = pbc_pkg::MASK_ALL;
        else if (w == pbc_pkg::OFF_SEC_IO) wmask = pbc_pkg::MASK_LOW16;
        else if (w == pbc_pkg::OFF_SEC_MEM) wmask = pbc_pkg::MASK_ALL;
        else if (w == pbc_pkg::OFF_DEC_Q) wmask = pbc_pkg::MASK_ALL;
        else wmask = pbc_pkg::MASK_NONE;
    endfunction : wmask

    assign be_mask = {{8{cfg_byte_en_in[3]}}, {8{cfg_byte_en_in[2]}},
                      {8{cfg_byte_en_in[1]}}, {8{cfg_byte_en_in[0]}}};
    // Requests arriving while one is in flight are dropped, not queued
    assign take = cfg_req_in && !s_reg.pend && !s_reg.ack;
    assign wr_take = take && cfg_write_in;
    assign irq_raw_b = {downstream_irq_d_b_in, downstream_irq_c_b_in,
                        downstream_irq_b_b_in, downstream_irq_a_b_in};

    pbc_word_store #(
        .WIDTH(32),
        .DEPTH(32),
        .AW(5)
    ) u_store (
        .clk_in(clk_in),
        .rst_b_in(rst_b),
        .wr_en_in(wr_take),
        .wr_addr_in(cfg_addr_in[6:2]),
        .wr_mask_in(wmask(cfg_addr_in) & be_mask),
        .wr_data_in(cfg_wdata_in),
        .rd_addr_in(cfg_addr_in[6:2]),
        .rd_data_out(mem_rdata)
    );

    always_comb begin
        logic [7:0] w;
        logic [31:0] rd;
        logic [1:0] ps;
        s_next = s_reg;
        w = {s_reg.addr[7:2], 2'h0};
        rd = pbc_pkg::RESET_ZERO;
        ps = cfg_wdata_in[pbc_pkg::PM_STATE_LSB +: 2];
        s_next.ack = 1'b0;
        s_next.irq_meta = irq_raw_b;
        s_next.irq_sync = s_reg.irq_meta;
        // Clear steering bit keeps the core input, set bit drives the pin
        for (int i = 0; i < SB; i++) begin
            s_next.core_b[i] = s_reg.steer[i] | s_reg.irq_sync[i];
            s_next.pin_oe[i] = s_reg.steer[i] & ~s_reg.irq_sync[i];
        end
        s_next.pend = take;
        if (take) begin
            s_next.addr = cfg_addr_in;
            s_next.write = cfg_write_in;
        end
        // Events set status; set beats a same-cycle clear
        if (wr_take && {cfg_addr_in[7:2], 2'h0} == pbc_pkg::OFF_UP_STAT) begin
            s_next.up_stat = s_reg.up_stat & ~(cfg_wdata_in[UP_EV_W:0] & be_mask[UP_EV_W:0]);
        end
        if (wr_take && {cfg_addr_in[7:2], 2'h0} == pbc_pkg::OFF_DN_STAT) begin
            s_next.dn_stat = s_reg.dn_stat & ~(cfg_wdata_in[DN_EV_W-1:0] & be_mask[DN_EV_W-1:0]);
        end
        if (wr_take && {cfg_addr_in[7:2], 2'h0} == pbc_pkg::OFF_PM_CSR && cfg_byte_en_in[0]) begin
            s_next.pm_state = ps;
            if ((s_reg.pm_state == pbc_pkg::PM_D0 && ps == pbc_pkg::PM_D3) ||
                (s_reg.pm_state == pbc_pkg::PM_D3 && ps == pbc_pkg::PM_D0)) begin
                s_next.up_stat[pbc_pkg::UP_PST_BIT] = 1'b1;
            end
        end
        if (wr_take && {cfg_addr_in[7:2], 2'h0} == pbc_pkg::OFF_STEER && cfg_byte_en_in[0]) begin
            s_next.steer = cfg_wdata_in[SB-1:0];
        end
        if (wr_take && {cfg_addr_in[7:2], 2'h0} == pbc_pkg::OFF_CMD_STAT && cfg_byte_en_in[2]) begin
            s_next.cap_flag = cfg_wdata_in[pbc_pkg::CAP_STAT_BIT];
        end
        s_next.up_stat[UP_EV_W-1:0] = s_next.up_stat[UP_EV_W-1:0] | upstream_event_in;
        s_next.dn_stat = s_next.dn_stat | downstream_event_in;
        // Read data combine stored bits with the fixed fields
        if (w == pbc_pkg::OFF_ID) rd = {DEVICE_CODE, VENDOR_CODE};
        else if (w == pbc_pkg::OFF_CMD_STAT) begin
            rd = mem_rdata & pbc_pkg::MASK_CMD;
            rd[pbc_pkg::CAP_STAT_BIT] = s_reg.cap_flag;
        end
        else if (w == pbc_pkg::OFF_CLASS_REV) rd = {pbc_pkg::CLASS_BRIDGE, REVISION_CODE};
        else if (w == pbc_pkg::OFF_HDR_MISC) rd = {8'h00, pbc_pkg::HDR_TYPE_BRIDGE, mem_rdata[15:0]};
        else if (w == pbc_pkg::OFF_CAP_PTR) rd = {24'h000000, pbc_pkg::OFF_PM_HDR};
        else if (w == pbc_pkg::OFF_UP_STAT) rd = 32'(s_reg.up_stat);
        else if (w == pbc_pkg::OFF_DN_STAT) rd = 32'(s_reg.dn_stat);
        else if (w == pbc_pkg::OFF_STEER) rd = 32'(s_reg.steer);
        else if (w == pbc_pkg::OFF_PM_HDR) rd = {PM_CAPS, pbc_pkg::PM_NEXT_PTR, pbc_pkg::PM_CAP_ID};
        else if (w == pbc_pkg::OFF_PM_CSR) rd = {8'h00, 8'h00, 14'h0000, s_reg.pm_state};
        else rd = mem_rdata & wmask(s_reg.addr);
        if (s_reg.pend) begin
            s_next.ack = 1'b1;
            s_next.rdata = s_reg.write ? pbc_pkg::RESET_ZERO : rd;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.irq_meta <= '1;
            s_reg.irq_sync <= '1;
            s_reg.core_b <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cfg_rdata_out = s_reg.rdata;
    assign cfg_ack_out = s_reg.ack;
    assign core_irq_in_0_b_out = s_reg.core_b[0];
    assign core_irq_in_1_b_out = s_reg.core_b[1];
    assign core_irq_in_2_b_out = s_reg.core_b[2];
    assign core_irq_in_3_b_out = s_reg.core_b[3];
    // Open-drain pins only ever pull low; the level comes from the enable
    assign upstream_irq_pin_a_b_out = 1'b0;
    assign upstream_irq_pin_b_b_out = 1'b0;
    assign upstream_irq_pin_c_b_out = 1'b0;
    assign upstream_irq_pin_d_b_out = 1'b0;
    assign upstream_irq_pin_a_oe_out = s_reg.pin_oe[0];
    assign upstream_irq_pin_b_oe_out = s_reg.pin_oe[1];
    assign upstream_irq_pin_c_oe_out = s_reg.pin_oe[2];
    assign upstream_irq_pin_d_oe_out = s_reg.pin_oe[3];

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b);

    sequence req_taken_s;
        take;
    endsequence
    sequence answer_s;
        !cfg_ack_out ##1 cfg_ack_out;
    endsequence
    sequence read_done_s(logic [7:0] off);
        cfg_ack_out && !s_reg.write && {s_reg.addr[7:2], 2'h0} == off;
    endsequence
    // Pin held low over three edges walks both sync stages and the output flop
    sequence core_a_low_s;
        (!s_reg.steer[0] && !downstream_irq_a_b_in) [*3];
    endsequence
    sequence pin_d_low_s;
        (s_reg.steer[3] && !downstream_irq_d_b_in) [*3];
    endsequence

    ack_latency_a: assert property (req_taken_s |=> answer_s)
        else $error("answer not two cycles after request");
    ack_pulse_a: assert property (cfg_ack_out |=> !cfg_ack_out)
        else $error("answer held longer than one cycle");
    refuse_window_a: assert property (req_taken_s |=> !take ##1 !take)
        else $error("request taken inside busy window");
    write_rdata_a: assert property ((cfg_ack_out && s_reg.write) |-> cfg_rdata_out == 32'h0000_0000)
        else $error("write answer carried data");
    steer_a_route_a: assert property ((!s_reg.steer[0] && !s_reg.irq_sync[0]) |=>
        !core_irq_in_0_b_out && !upstream_irq_pin_a_oe_out)
        else $error("line A routed wrongly");
    core0_path_a: assert property (core_a_low_s |=> !core_irq_in_0_b_out)
        else $error("line A did not reach core input 0");
    steer_b_route_a: assert property (s_reg.steer[1] |=> core_irq_in_1_b_out)
        else $error("line B reached core while steered to pin");
    steer_c_route_a: assert property (!s_reg.steer[2] |=> !upstream_irq_pin_c_oe_out)
        else $error("pin C driven while steered to core");
    steer_d_route_a: assert property ((s_reg.steer[3] && !s_reg.irq_sync[3]) |=> upstream_irq_pin_d_oe_out)
        else $error("pin D not driven");
    pin_d_path_a: assert property (pin_d_low_s |=> upstream_irq_pin_d_oe_out)
        else $error("line D did not reach pin D");
    pm_header_a: assert property (read_done_s(pbc_pkg::OFF_PM_HDR) |->
        cfg_rdata_out == {PM_CAPS, pbc_pkg::PM_NEXT_PTR, pbc_pkg::PM_CAP_ID})
        else $error("power header layout wrong");
    pm_csr_top_a: assert property (read_done_s(pbc_pkg::OFF_PM_CSR) |-> cfg_rdata_out[31:16] == 16'h0000)
        else $error("power control upper bytes not zero");
    pm_csr_low_a: assert property (read_done_s(pbc_pkg::OFF_PM_CSR) |-> cfg_rdata_out[15:2] == 14'h0000)
        else $error("power control unused bits set");
    pm_transition_a: assert property ((wr_take && {cfg_addr_in[7:2], 2'h0} == pbc_pkg::OFF_PM_CSR &&
        cfg_byte_en_in[0] && s_reg.pm_state == pbc_pkg::PM_D0 &&
        cfg_wdata_in[pbc_pkg::PM_STATE_LSB +: 2] == pbc_pkg::PM_D3) |=> s_reg.up_stat[pbc_pkg::UP_PST_BIT])
        else $error("power transition not flagged");
    up_event_a: assert property (upstream_event_in[0] |=> s_reg.up_stat[0])
        else $error("upstream event lost");
    dn_event_a: assert property (downstream_event_in[0] |=> s_reg.dn_stat[0])
        else $error("downstream event lost");
    up_stat_top_a: assert property (read_done_s(pbc_pkg::OFF_UP_STAT) |->
        (cfg_rdata_out >> (UP_EV_W + 1)) == 32'h0000_0000)
        else $error("upstream status reserved bits set");
    dn_stat_top_a: assert property (read_done_s(pbc_pkg::OFF_DN_STAT) |->
        (cfg_rdata_out >> DN_EV_W) == 32'h0000_0000)
        else $error("downstream status reserved bits set");
    steer_read_a: assert property (read_done_s(pbc_pkg::OFF_STEER) |->
        cfg_rdata_out == 32'(s_reg.steer))
        else $error("steering readback wrong");
    steer_top_a: assert property (read_done_s(pbc_pkg::OFF_STEER) |->
        (cfg_rdata_out >> SB) == 32'h0000_0000)
        else $error("steering reserved bits set");
    cap_ptr_a: assert property (read_done_s(pbc_pkg::OFF_CAP_PTR) |-> cfg_rdata_out == 32'h0000_0068)
        else $error("capability pointer wrong");
    cap_flag_a: assert property (read_done_s(pbc_pkg::OFF_CMD_STAT) |->
        cfg_rdata_out[pbc_pkg::CAP_STAT_BIT] == s_reg.cap_flag)
        else $error("capabilities flag readback wrong");
    reserved_zero_a: assert property (read_done_s(8'h60) |-> cfg_rdata_out == 32'h0000_0000)
        else $error("reserved location not zero");
    hdr_type_a: assert property (read_done_s(pbc_pkg::OFF_HDR_MISC) |->
        cfg_rdata_out[31:16] == {8'h00, pbc_pkg::HDR_TYPE_BRIDGE})
        else $error("header type wrong");
    id_word_a: assert property (read_done_s(pbc_pkg::OFF_ID) |-> cfg_rdata_out == {DEVICE_CODE, VENDOR_CODE})
        else $error("identification word wrong");
    class_rev_a: assert property (read_done_s(pbc_pkg::OFF_CLASS_REV) |->
        cfg_rdata_out == {pbc_pkg::CLASS_BRIDGE, REVISION_CODE})
        else $error("class and revision wrong");
endmodule : pbc_config_space
`default_nettype wire

// ==== pbc_host_model.sv ====
// Configuration master model that drives the request port of the bridge space
`default_nettype none
module pbc_host_model (
    input wire logic clk_in,
    input wire logic cfg_ack_in,
    input wire logic [31:0] cfg_rdata_in,
    output logic cfg_req_out,
    output logic cfg_write_out,
    output logic [7:0] cfg_addr_out,
    output logic [3:0] cfg_byte_en_out,
    output logic [31:0] cfg_wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int misses = 0;
    initial begin
        cfg_req_out = 1'b0;
        cfg_write_out = 1'b0;
        cfg_addr_out = 8'h00;
        cfg_byte_en_out = 4'h0;
        cfg_wdata_out = 32'h0;
    end
    // Gap idles the master first, so both prompt and slow masters are seen
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] data, input int gap, output logic [31:0] rd);
        int n;
        n = 0;
        repeat (gap + 1) @(posedge clk_in);
        #1;
        cfg_req_out = 1'b1;
        cfg_write_out = wr;
        cfg_addr_out = addr;
        cfg_byte_en_out = be;
        cfg_wdata_out = data;
        // Answer and data are taken at the rising edge that samples the acknowledge
        do begin
            @(posedge clk_in);
            n++;
        end while (cfg_ack_in !== 1'b1 && n < 20);
        if (cfg_ack_in !== 1'b1) begin
            misses++;
        end
        rd = cfg_rdata_in;
        #1;
        cfg_req_out = 1'b0;
        // Released lines show the inverse so a stale value cannot pass as a good one
        cfg_write_out = ~wr;
        cfg_addr_out = ~addr;
        cfg_byte_en_out = ~be;
        cfg_wdata_out = ~data;
    endtask : xfer
endmodule : pbc_host_model
`default_nettype wire

// ==== pbc_pkg.sv ====
// Constants for the bridge configuration space block
`default_nettype none
package pbc_pkg;
    localparam logic [7:0] OFF_ID = 8'h00;
    localparam logic [7:0] OFF_CMD_STAT = 8'h04;
    localparam logic [7:0] OFF_CLASS_REV = 8'h08;
    localparam logic [7:0] OFF_HDR_MISC = 8'h0c;
    localparam logic [7:0] OFF_BUS_NUM = 8'h18;
    localparam logic [7:0] OFF_IO_WIN = 8'h1c;
    localparam logic [7:0] OFF_MEM_WIN = 8'h20;
    localparam logic [7:0] OFF_PF_WIN = 8'h24;
    localparam logic [7:0] OFF_CAP_PTR = 8'h34;
    localparam logic [7:0] OFF_BRIDGE_CTL = 8'h3c;
    localparam logic [7:0] OFF_EXT_CTL = 8'h40;
    localparam logic [7:0] OFF_UP_STAT = 8'h44;
    localparam logic [7:0] OFF_DN_STAT = 8'h48;
    localparam logic [7:0] OFF_ARB_CTL = 8'h4c;
    localparam logic [7:0] OFF_STEER = 8'h50;
    localparam logic [7:0] OFF_SEC_IO = 8'h54;
    localparam logic [7:0] OFF_SEC_MEM = 8'h58;
    localparam logic [7:0] OFF_DEC_Q = 8'h5c;
    localparam logic [7:0] OFF_PM_HDR = 8'h68;
    localparam logic [7:0] OFF_PM_CSR = 8'h6c;
    // Writable bits of the plain stored registers
    localparam logic [31:0] MASK_NONE = 32'h0000_0000;
    localparam logic [31:0] MASK_ALL = 32'hffff_ffff;
    localparam logic [31:0] MASK_LOW16 = 32'h0000_ffff;
    localparam logic [31:0] MASK_HIGH16 = 32'hffff_0000;
    localparam logic [31:0] MASK_CMD = 32'h0000_03ff;
    localparam int STEER_BITS = 4;
    localparam int CAP_STAT_BIT = 20;
    localparam int PM_STATE_LSB = 0;
    localparam logic [1:0] PM_D0 = 2'h0;
    localparam logic [1:0] PM_D3 = 2'h3;
    localparam int UP_PST_BIT = 6;
    localparam logic [7:0] PM_CAP_ID = 8'h01;
    localparam logic [7:0] PM_NEXT_PTR = 8'h00;
    localparam logic [7:0] HDR_TYPE_BRIDGE = 8'h01;
    localparam logic [23:0] CLASS_BRIDGE = 24'h060400;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : pbc_pkg
`default_nettype wire

// ==== pbc_word_store.sv ====
// Small word memory with bit write mask and registered read data
`default_nettype none
module pbc_word_store #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_mask_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_depth_check
        $error("pbc_word_store: DEPTH exceeds address range");
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            rd_data_out <= '0;
        end else begin
            if (wr_en_in) begin
                mem_reg[wr_addr_in] <= (mem_reg[wr_addr_in] & ~wr_mask_in) | (wr_data_in & wr_mask_in);
            end
            rd_data_out <= mem_reg[rd_addr_in];
        end
    end
endmodule : pbc_word_store
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the bridge configuration space
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] CAPS = 16'h0002;
    localparam logic [31:0] IDW = 32'h3c5a_a5c3; // Arbitrary value
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] up_ev = 6'h00;
    logic [6:0] dn_ev = 7'h00;
    logic [3:0] irq_b = 4'hf;
    logic req, wr, ack;
    logic [7:0] addr;
    logic [3:0] be, core_b, pin_b, oe;
    logic [31:0] wdata, rdata, q;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    pbc_host_model host (.clk_in(clk), .cfg_ack_in(ack), .cfg_rdata_in(rdata), .cfg_req_out(req),
        .cfg_write_out(wr), .cfg_addr_out(addr), .cfg_byte_en_out(be), .cfg_wdata_out(wdata));
    // Pins are open drain with a pull-up, so the wire level comes from the enables
    pbc_config_space #(.PM_CAPS(CAPS), .VENDOR_CODE(IDW[15:0]), .DEVICE_CODE(IDW[31:16])) dut (.clk_in(clk),
        .rst_b_in(rst_b), .cfg_req_in(req),
        .cfg_write_in(wr), .cfg_addr_in(addr), .cfg_byte_en_in(be), .cfg_wdata_in(wdata),
        .cfg_rdata_out(rdata), .cfg_ack_out(ack), .upstream_event_in(up_ev), .downstream_event_in(dn_ev),
        .downstream_irq_a_b_in(irq_b[0]), .downstream_irq_b_b_in(irq_b[1]),
        .downstream_irq_c_b_in(irq_b[2]), .downstream_irq_d_b_in(irq_b[3]),
        .core_irq_in_0_b_out(core_b[0]), .core_irq_in_1_b_out(core_b[1]),
        .core_irq_in_2_b_out(core_b[2]), .core_irq_in_3_b_out(core_b[3]),
        .upstream_irq_pin_a_b_in(~oe[0]), .upstream_irq_pin_b_b_in(~oe[1]),
        .upstream_irq_pin_c_b_in(~oe[2]), .upstream_irq_pin_d_b_in(~oe[3]),
        .upstream_irq_pin_a_b_out(pin_b[0]), .upstream_irq_pin_b_b_out(pin_b[1]),
        .upstream_irq_pin_c_b_out(pin_b[2]), .upstream_irq_pin_d_b_out(pin_b[3]),
        .upstream_irq_pin_a_oe_out(oe[0]), .upstream_irq_pin_b_oe_out(oe[1]),
        .upstream_irq_pin_c_oe_out(oe[2]), .upstream_irq_pin_d_oe_out(oe[3]));
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // Ceiling is about twenty times the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        host.xfer(1'b0, a, 4'h0, 32'h0, 0, d);
    endtask : rd
    task automatic wrt(input logic [7:0] a, input logic [31:0] d, input logic [3:0] e);
        logic [31:0] dummy;
        host.xfer(1'b1, a, e, d, 1, dummy);
    endtask : wrt
    task automatic test_reset_map;
        rd(pbc_pkg::OFF_STEER, q); chk("steering reset", 32'h0, q);
        rd(pbc_pkg::OFF_CAP_PTR, q); chk("capability pointer", 32'h0000_0068, q);
        rd(pbc_pkg::OFF_CMD_STAT, q); chk("capability flag", 32'h0, q & 32'h0010_0000);
        rd(pbc_pkg::OFF_PM_HDR, q); chk("power header", {CAPS, pbc_pkg::PM_NEXT_PTR, pbc_pkg::PM_CAP_ID}, q);
        rd(pbc_pkg::OFF_PM_CSR, q); chk("power control reset", 32'h0, q);
        rd(8'h60, q); chk("reserved 60", 32'h0, q);
        rd(8'h70, q); chk("past power block", 32'h0, q);
        rd(pbc_pkg::OFF_ID, q); chk("identification", IDW, q);
        rd(pbc_pkg::OFF_CLASS_REV, q); chk("class code", {pbc_pkg::CLASS_BRIDGE, 8'h00}, q & 32'hffff_ff00);
        rd(pbc_pkg::OFF_HDR_MISC, q); chk("header type", {8'h00, pbc_pkg::HDR_TYPE_BRIDGE, 16'h0000}, q);
        wrt(8'h60, 32'hffff_ffff, 4'hf);
        rd(8'h60, q); chk("reserved write", 32'h0, q);
        wrt(pbc_pkg::OFF_PM_HDR, 32'h0, 4'hf);
        rd(pbc_pkg::OFF_PM_HDR, q);
        chk("power header write", {CAPS, pbc_pkg::PM_NEXT_PTR, pbc_pkg::PM_CAP_ID}, q);
    endtask : test_reset_map
    task automatic test_steering;
        for (int i = 0; i < 4; i++) begin
            wrt(pbc_pkg::OFF_STEER, 32'hffff_fff0 | (32'h1 << i), 4'hf);
            rd(pbc_pkg::OFF_STEER, q); chk("steering value", 32'h1 << i, q);
            @(posedge clk); #1 irq_b = 4'h0;
            repeat (5) @(posedge clk);
            #1;
            chk("core inputs", {28'h0, 4'h1 << i}, {28'h0, core_b});
            chk("pin enables", {28'h0, 4'h1 << i}, {28'h0, oe});
            chk("pin values", 32'h0, {28'h0, pin_b});
            irq_b = 4'hf;
            repeat (5) @(posedge clk);
            #1;
            chk("idle lines", 32'h0000_00f0, {24'h0, core_b, oe});
        end
        wrt(pbc_pkg::OFF_STEER, 32'hf, 4'h0);
        rd(pbc_pkg::OFF_STEER, q); chk("no byte enabled", 32'h8, q);
    endtask : test_steering
    task automatic test_status;
        @(posedge clk); #1 up_ev = 6'h3f; dn_ev = 7'h7f;
        @(posedge clk); #1 up_ev = 6'h00; dn_ev = 7'h00;
        rd(pbc_pkg::OFF_UP_STAT, q); chk("upstream set", 32'h3f, q);
        rd(pbc_pkg::OFF_DN_STAT, q); chk("downstream set", 32'h7f, q);
        wrt(pbc_pkg::OFF_UP_STAT, 32'h5, 4'hf);
        rd(pbc_pkg::OFF_UP_STAT, q); chk("upstream partial clear", 32'h3a, q);
        wrt(pbc_pkg::OFF_DN_STAT, 32'hffff_ffff, 4'hf);
        rd(pbc_pkg::OFF_DN_STAT, q); chk("downstream clear", 32'h0, q);
        wrt(pbc_pkg::OFF_UP_STAT, 32'hff, 4'hf);
    endtask : test_status
    task automatic test_power;
        wrt(pbc_pkg::OFF_PM_CSR, 32'hffff_ffff, 4'hf);
        rd(pbc_pkg::OFF_PM_CSR, q); chk("power state low", 32'h3, q);
        rd(pbc_pkg::OFF_UP_STAT, q); chk("transition to low", 32'h40, q);
        wrt(pbc_pkg::OFF_UP_STAT, 32'h40, 4'hf);
        wrt(pbc_pkg::OFF_PM_CSR, 32'h0, 4'hf);
        rd(pbc_pkg::OFF_UP_STAT, q); chk("transition to full", 32'h40, q);
    endtask : test_power
    task automatic test_cap_flag;
        wrt(pbc_pkg::OFF_CMD_STAT, 32'hffff_ffff, 4'hf);
        rd(pbc_pkg::OFF_CMD_STAT, q); chk("command and flag", 32'h0010_03ff, q);
        wrt(pbc_pkg::OFF_CMD_STAT, 32'h0, 4'hf);
        rd(pbc_pkg::OFF_CMD_STAT, q); chk("flag cleared", 32'h0, q);
    endtask : test_cap_flag
    initial begin
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        test_reset_map();
        test_steering();
        test_status();
        test_power();
        test_cap_flag();
        chk("answer misses", 32'h0, 32'(host.misses));
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
